// >>> hw/hyp_ctrl_pkg.sv
// package: register map, field positions and encodings of the hypervisor trap block
package hyp_ctrl_pkg;

  // ***************************************************************
  // register bus map (word aligned byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CFG_LO     = 8'h00;
  localparam logic [7:0] ADDR_CFG_HI     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_LIVE       = 8'h14;

  // ***************************************************************
  // hypervisor_config field positions (64-bit view)
  // ***************************************************************
  localparam int POS_MONITOR_VIRT_OFFSET_ENABLE  = 51;
  localparam int POS_TRAP_ICACHE_INVAL_ALL_INNER = 50;
  localparam int POS_TRAP_CACHE_ID_GROUP         = 49;
  localparam int POS_GRANULE_FAULT_ROUTE         = 48;
  localparam int POS_FAULT_INJECTION_ENABLE      = 47;
  localparam int POS_FORCED_WRITEBACK_COMBINE    = 46;
  localparam int CFG_FIELD_LSB                   = 46;
  localparam int CFG_FIELD_W                     = 6;
  // same fields as seen in the upper 32-bit word
  localparam int HI_LSB                          = CFG_FIELD_LSB - 32;

  // index of each field inside the 6-bit held vector
  localparam int F_FWB  = 0;
  localparam int F_FAULT_INJECTION_ACCESS_ENABLE = 1;
  localparam int F_GPF  = 2;
  localparam int F_TID  = 3;
  localparam int F_TIC  = 4;
  localparam int F_AMV  = 5;

  // warm reset leaves the fields unknown; zero is the value we pick
  localparam logic [CFG_FIELD_W-1:0] CFG_RESET = 6'h00;

  // ***************************************************************
  // interrupt status bits
  // ***************************************************************
  localparam int IRQ_W          = 4;
  localparam int IRQ_ICACHE     = 0;
  localparam int IRQ_ID_GROUP   = 1;
  localparam int IRQ_FAULT_INJ  = 2;
  localparam int IRQ_GPF_ROUTE  = 3;

  // ***************************************************************
  // trap reporting and memory attribute encodings
  // ***************************************************************
  localparam logic [5:0] EC_SYS_TRAP   = 6'h18;
  localparam logic [5:0] EC_NONE       = 6'h00;
  localparam logic [1:0] DEV_NGNRNE    = 2'h0;
  localparam logic [1:0] DEV_GRE       = 2'h3;
  localparam logic [1:0] ALLOC_RA_WA   = 2'h3;
  localparam logic [1:0] S2_CACHE_WB   = 2'h3;
  localparam logic [1:0] S2_FWB_KEEP   = 2'h3;
  localparam logic [1:0] S2_FWB_WB     = 2'h2;

  // kinds of access presented for trap checking
  typedef enum logic [2:0] {
    ACC_ICACHE_ALL_INNER,
    ACC_ICACHE_POU,
    ACC_ID_READ,
    ACC_ID_SELECT_WRITE,
    ACC_FAULT_GEN_REG,
    ACC_GRANULE_ABORT,
    ACC_OTHER
  } access_kind_type;

endpackage : hyp_ctrl_pkg

// >>> hw/hyp_trap_and_s2_attr_ctrl.sv
// module: hypervisor trap controls (bits 51..46) and forced write-back stage 2 combine
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module hyp_trap_and_s2_attr_ctrl #(
  parameter bit HAS_AMU_OFFSETS = 1'b1,
  parameter bit HAS_EVT         = 1'b1,
  parameter bit HAS_GRANULE_PROT = 1'b1,
  parameter bit HAS_RAS_FI      = 1'b1,
  parameter bit HAS_S2_FWB      = 1'b1,
  parameter bit HAS_VHE         = 1'b1,
  parameter bit HAS_MTE         = 1'b1,
  parameter bit TRAP_ICACHE_POU = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        irq,
  // processor context
  input  wire logic        el2_enabled,
  input  wire logic        host_el2_mode,
  input  wire logic        general_exception_trap,
  input  wire logic        pou_before_icache,
  input  wire logic [15:0] error_record_count,
  input  wire logic        fi_model_owned,
  // access check request
  input  wire logic        acc_valid,
  input  wire logic [2:0]  acc_kind,
  input  wire logic        acc_from_el1,
  input  wire logic        acc_from_el0,
  output var  logic        acc_done,
  output var  logic        acc_trap_el2,
  output var  logic [5:0]  acc_ec,
  // activity monitor view
  input  wire logic [63:0] monitor_offset_in,
  output var  logic        monitor_virt_on,
  output var  logic [63:0] monitor_offset_out,
  // stage 2 attribute combine request
  input  wire logic        tlb_invalidate,
  input  wire logic        xl_valid,
  input  wire logic [3:0]  s2_attr,
  input  wire logic        s1_device,
  input  wire logic [1:0]  s1_dev_kind,
  input  wire logic        s1_cacheable,
  input  wire logic        s1_wb,
  input  wire logic [1:0]  s1_alloc,
  input  wire logic        s1_tagged,
  output var  logic        xl_done,
  output var  logic        fin_device,
  output var  logic [1:0]  fin_dev_kind,
  output var  logic        fin_cacheable,
  output var  logic        fin_wb,
  output var  logic [1:0]  fin_alloc,
  output var  logic        fin_tagged,
  output var  logic        fin_s2_bit5_ignored
);

  // ***************************************************************
  // decode helpers
  // ***************************************************************

  // stronger device kind is the lower code
  function automatic logic [1:0] dev_min(input logic [1:0] a, input logic [1:0] b);
    dev_min = (a < b) ? a : b;
  endfunction : dev_min

  // register hit on a strobe
  function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
    hit = stb && (a == off);
  endfunction : hit

  // ***************************************************************
  // implemented field mask
  // ***************************************************************
  logic [hyp_ctrl_pkg::CFG_FIELD_W-1:0] impl_mask;
  logic                                 fault_injection_access_enable_res0;

  // error record absence may pin the enable at zero
  assign fault_injection_access_enable_res0 = (error_record_count == 16'h0000) || !fi_model_owned;

  // absent features hold zero and drop writes
  always_comb
  begin
    impl_mask                             = '0;
    impl_mask[hyp_ctrl_pkg::F_AMV]  = HAS_AMU_OFFSETS;
    impl_mask[hyp_ctrl_pkg::F_TIC]  = HAS_EVT;
    impl_mask[hyp_ctrl_pkg::F_TID]  = HAS_EVT;
    impl_mask[hyp_ctrl_pkg::F_GPF]  = HAS_GRANULE_PROT;
    impl_mask[hyp_ctrl_pkg::F_FAULT_INJECTION_ACCESS_ENABLE] = HAS_RAS_FI && !fault_injection_access_enable_res0;
    impl_mask[hyp_ctrl_pkg::F_FWB]  = HAS_S2_FWB;
  end

  // ***************************************************************
  // configuration fields
  // ***************************************************************
  logic [hyp_ctrl_pkg::CFG_FIELD_W-1:0] cfg_r;
  logic [hyp_ctrl_pkg::CFG_FIELD_W-1:0] cfg_nxt;
  logic [hyp_ctrl_pkg::CFG_FIELD_W-1:0] cfg_view;

  assign cfg_nxt = reg_wdata[hyp_ctrl_pkg::HI_LSB +: hyp_ctrl_pkg::CFG_FIELD_W] & impl_mask;
  // masking the view too covers a record count that drops after a write
  assign cfg_view = cfg_r & impl_mask;

  // warm reset picks zero; software must still program every field
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cfg_r <= hyp_ctrl_pkg::CFG_RESET;
    else if (hit(reg_wr, reg_addr, hyp_ctrl_pkg::ADDR_CFG_HI))
      cfg_r <= cfg_nxt;
  end

  // ***************************************************************
  // effective control values
  // ***************************************************************
  logic host_mode_on;
  logic eff_tic;
  logic eff_tid;
  logic eff_fault_injection_access_enable;
  logic eff_gpf;

  assign host_mode_on = HAS_VHE && host_el2_mode && general_exception_trap;
  // direct reads still show the stored bits
  assign eff_tic  = cfg_view[hyp_ctrl_pkg::F_TIC] && !host_mode_on;
  assign eff_tid  = cfg_view[hyp_ctrl_pkg::F_TID] && !host_mode_on;
  assign eff_fault_injection_access_enable = cfg_view[hyp_ctrl_pkg::F_FAULT_INJECTION_ACCESS_ENABLE] || !el2_enabled;
  assign eff_gpf  = cfg_view[hyp_ctrl_pkg::F_GPF];

  // ***************************************************************
  // trap decision for one presented access
  // ***************************************************************
  hyp_ctrl_pkg::access_kind_type kind;
  logic                          trap_now;
  logic [hyp_ctrl_pkg::IRQ_W-1:0] evt;

  assign kind = hyp_ctrl_pkg::access_kind_type'(acc_kind);

  always_comb
  begin
    trap_now = 1'b0;
    evt      = '0;
    if (acc_valid)
    begin
      unique case (kind)
        hyp_ctrl_pkg::ACC_ICACHE_ALL_INNER:
        begin
          trap_now = eff_tic && el2_enabled && acc_from_el1;
          evt[hyp_ctrl_pkg::IRQ_ICACHE] = trap_now;
        end
        hyp_ctrl_pkg::ACC_ICACHE_POU:
        begin
          // optional extension of the same trap when no icache sits before unification
          trap_now = TRAP_ICACHE_POU && pou_before_icache && eff_tic
                     && el2_enabled && acc_from_el1;
          evt[hyp_ctrl_pkg::IRQ_ICACHE] = trap_now;
        end
        hyp_ctrl_pkg::ACC_ID_READ, hyp_ctrl_pkg::ACC_ID_SELECT_WRITE:
        begin
          trap_now = eff_tid && el2_enabled && acc_from_el1;
          evt[hyp_ctrl_pkg::IRQ_ID_GROUP] = trap_now;
        end
        hyp_ctrl_pkg::ACC_FAULT_GEN_REG:
        begin
          trap_now = !eff_fault_injection_access_enable && el2_enabled && acc_from_el1;
          evt[hyp_ctrl_pkg::IRQ_FAULT_INJ] = trap_now;
        end
        hyp_ctrl_pkg::ACC_GRANULE_ABORT:
        begin
          trap_now = eff_gpf && (acc_from_el0 || acc_from_el1);
          evt[hyp_ctrl_pkg::IRQ_GPF_ROUTE] = trap_now;
        end
        hyp_ctrl_pkg::ACC_OTHER:
          trap_now = 1'b0;
        default:
          trap_now = 1'b0;
      endcase
    end
  end

  // answer one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      acc_done     <= 1'b0;
      acc_trap_el2 <= 1'b0;
      acc_ec       <= hyp_ctrl_pkg::EC_NONE;
    end
    else
    begin
      acc_done     <= acc_valid;
      acc_trap_el2 <= trap_now;
      // aborts keep their own class; system access traps report 0x18
      acc_ec       <= (trap_now && kind != hyp_ctrl_pkg::ACC_GRANULE_ABORT)
                      ? hyp_ctrl_pkg::EC_SYS_TRAP : hyp_ctrl_pkg::EC_NONE;
    end
  end

  // ***************************************************************
  // activity monitor offset view
  // ***************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      monitor_virt_on    <= 1'b0;
      monitor_offset_out <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      monitor_virt_on    <= cfg_view[hyp_ctrl_pkg::F_AMV];
      monitor_offset_out <= cfg_view[hyp_ctrl_pkg::F_AMV] ? monitor_offset_in
                            : 64'h0000_0000_0000_0000;
    end
  end

  // ***************************************************************
  // cached forced write-back copy
  // ***************************************************************
  logic fwb_cached_r;

  // a write alone does not reach translation; stale until invalidated
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      fwb_cached_r <= 1'b0;
    else if (tlb_invalidate)
      fwb_cached_r <= cfg_view[hyp_ctrl_pkg::F_FWB];
  end

  // ***************************************************************
  // stage 1 / stage 2 attribute combine
  // ***************************************************************
  logic       c_device;
  logic [1:0] c_kind;
  logic       c_cacheable;
  logic       c_wb;
  logic [1:0] c_alloc;

  // no security gating: one control serves both stage 2 tables
  always_comb
  begin
    c_device    = 1'b0;
    c_kind      = hyp_ctrl_pkg::DEV_GRE;
    c_cacheable = 1'b0;
    c_wb        = 1'b0;
    c_alloc     = s1_alloc;
    if (!fwb_cached_r)
    begin
      // baseline: bits 3..2 outer/inner pair, outer 00 means device
      if (s2_attr[3:2] == 2'h0)
      begin
        c_device = 1'b1;
        c_kind   = s1_device ? dev_min(s1_dev_kind, s2_attr[1:0]) : s2_attr[1:0];
      end
      else if (s1_device)
      begin
        c_device = 1'b1;
        c_kind   = s1_dev_kind;
      end
      else
      begin
        // stage 2 can only weaken cacheability, never strengthen it
        c_wb        = s1_wb && (s2_attr[3:2] == hyp_ctrl_pkg::S2_CACHE_WB)
                      && (s2_attr[1:0] == hyp_ctrl_pkg::S2_CACHE_WB);
        c_cacheable = s1_cacheable && (s2_attr[3:2] != 2'h1) && (s2_attr[1:0] != 2'h1);
      end
    end
    else if (s2_attr[2])
    begin
      // descriptor bit 5 (s2_attr[3]) is ignored in this mode
      if (s2_attr[1:0] == hyp_ctrl_pkg::S2_FWB_KEEP)
      begin
        c_device    = s1_device;
        c_kind      = s1_dev_kind;
        c_cacheable = !s1_device && s1_cacheable;
        c_wb        = !s1_device && s1_wb;
      end
      else if (s2_attr[1:0] == hyp_ctrl_pkg::S2_FWB_WB)
      begin
        c_cacheable = 1'b1;
        c_wb        = 1'b1;
      end
      else
      begin
        c_device = s1_device;
        c_kind   = s1_dev_kind;
      end
    end
    else
    begin
      c_device = 1'b1;
      c_kind   = s1_device ? dev_min(s1_dev_kind, s2_attr[1:0]) : s2_attr[1:0];
    end
    // hint follows stage 1 only where it had one
    if (fwb_cached_r && c_cacheable)
      c_alloc = s1_cacheable ? s1_alloc : hyp_ctrl_pkg::ALLOC_RA_WA;
  end

  // combined result, one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      xl_done             <= 1'b0;
      fin_device          <= 1'b0;
      fin_dev_kind        <= hyp_ctrl_pkg::DEV_NGNRNE;
      fin_cacheable       <= 1'b0;
      fin_wb              <= 1'b0;
      fin_alloc           <= 2'h0;
      fin_tagged          <= 1'b0;
      fin_s2_bit5_ignored <= 1'b0;
    end
    else
    begin
      xl_done             <= xl_valid;
      fin_device          <= c_device;
      fin_dev_kind        <= c_device ? c_kind : hyp_ctrl_pkg::DEV_NGNRNE;
      fin_cacheable       <= c_cacheable;
      fin_wb              <= c_wb;
      fin_alloc           <= c_cacheable ? c_alloc : 2'h0;
      fin_tagged          <= HAS_MTE && s1_tagged && c_cacheable && c_wb
                             && (c_alloc == hyp_ctrl_pkg::ALLOC_RA_WA);
      fin_s2_bit5_ignored <= fwb_cached_r;
    end
  end

  // ***************************************************************
  // interrupt status, enable and clear
  // ***************************************************************
  logic [hyp_ctrl_pkg::IRQ_W-1:0] irq_status_r;
  logic [hyp_ctrl_pkg::IRQ_W-1:0] irq_enable_r;
  logic [hyp_ctrl_pkg::IRQ_W-1:0] irq_clr;

  assign irq_clr = hit(reg_wr, reg_addr, hyp_ctrl_pkg::ADDR_IRQ_CLEAR)
                   ? reg_wdata[hyp_ctrl_pkg::IRQ_W-1:0] : '0;

  // a new event in the clear cycle survives the clear
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      irq_status_r <= '0;
    else
      irq_status_r <= (irq_status_r & ~irq_clr) | evt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      irq_enable_r <= '0;
    else if (hit(reg_wr, reg_addr, hyp_ctrl_pkg::ADDR_IRQ_ENABLE))
      irq_enable_r <= reg_wdata[hyp_ctrl_pkg::IRQ_W-1:0];
  end

  // follows status by one cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(irq_status_r & irq_enable_r);
  end

  // ***************************************************************
  // register read port
  // ***************************************************************
  logic [31:0] rd_word;

  // unmapped and write-only addresses read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (reg_addr)
      hyp_ctrl_pkg::ADDR_CFG_HI:
        rd_word[hyp_ctrl_pkg::HI_LSB +: hyp_ctrl_pkg::CFG_FIELD_W] = cfg_view;
      hyp_ctrl_pkg::ADDR_IRQ_STATUS:
        rd_word[hyp_ctrl_pkg::IRQ_W-1:0] = irq_status_r;
      hyp_ctrl_pkg::ADDR_IRQ_ENABLE:
        rd_word[hyp_ctrl_pkg::IRQ_W-1:0] = irq_enable_r;
      hyp_ctrl_pkg::ADDR_LIVE:
        rd_word[4:0] = {host_mode_on, eff_fault_injection_access_enable, eff_tid, eff_tic, fwb_cached_r};
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_word;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule : hyp_trap_and_s2_attr_ctrl

`default_nettype wire

// >>> tb/hyp_trap_and_s2_attr_ctrl_tb_top.sv
// testbench: register, trap, interrupt, monitor and stage 2 combine scenarios
`timescale 1ns/1ps
`default_nettype none

module hyp_trap_and_s2_attr_ctrl_tb_top;
  // ********
  // signals and tables
  // ********
  logic        core_clk, nrst, reg_wr, reg_rd, irq, el2_enabled, host_el2_mode;
  logic        general_exception_trap, pou_before_icache, fi_model_owned, acc_valid;
  logic        acc_from_el1, acc_from_el0, acc_done, acc_trap_el2, monitor_virt_on;
  logic        tlb_invalidate, xl_valid, s1_device, s1_cacheable, s1_wb, s1_tagged;
  logic        xl_done, fin_device, fin_cacheable, fin_wb, fin_tagged, fin_s2_bit5_ignored;
  logic [1:0]  s1_dev_kind, s1_alloc, fin_dev_kind, fin_alloc;
  logic [2:0]  acc_kind;
  logic [3:0]  s2_attr;
  logic [5:0]  acc_ec;
  logic [7:0]  reg_addr, fin_all;
  logic [15:0] error_record_count;
  logic [31:0] reg_wdata, reg_rdata;
  logic [63:0] monitor_offset_in, monitor_offset_out;
  int          mismatches, checks_done;
  // stage 2 bits 5..2, stage 1 and result as {dev, kind, cach, wb, alloc, tag}
  localparam logic [3:0] S2T [8] = '{4'h7, 4'h6, 4'h4, 4'h5, 4'h0, 4'h1, 4'h2, 4'h3};
  localparam logic [7:0] S1T [8] = '{8'h1B, 8'h01, 8'h1B, 8'hC0, 8'h1B, 8'h1B, 8'h1B, 8'h1B};
  localparam logic [7:0] EXT [8] = '{8'h1A, 8'h1F, 8'h00, 8'hC0, 8'h80, 8'hA0, 8'hC0, 8'hE0};

  assign fin_all = {fin_device, fin_dev_kind, fin_cacheable, fin_wb, fin_alloc, fin_tagged};

  hyp_trap_and_s2_attr_ctrl i_hyp_trap_and_s2_attr_ctrl (
    .core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .el2_enabled, .host_el2_mode, .general_exception_trap, .pou_before_icache,
    .error_record_count, .fi_model_owned, .acc_valid, .acc_kind, .acc_from_el1,
    .acc_from_el0, .acc_done, .acc_trap_el2, .acc_ec, .monitor_offset_in,
    .monitor_virt_on, .monitor_offset_out, .tlb_invalidate, .xl_valid, .s2_attr,
    .s1_device, .s1_dev_kind, .s1_cacheable, .s1_wb, .s1_alloc, .s1_tagged, .xl_done,
    .fin_device, .fin_dev_kind, .fin_cacheable, .fin_wb, .fin_alloc, .fin_tagged,
    .fin_s2_bit5_ignored
  );

  // ********
  // bus and request tasks
  // ********
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // strobe lowered on the taking edge, so back-to-back calls keep one gap cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    chk(what, reg_rdata, e);
  endtask : rd

  task automatic ctx(input logic el2, input logic host, input logic [15:0] cnt);
    @(posedge core_clk);
    el2_enabled            <= el2;
    host_el2_mode          <= host;
    general_exception_trap <= host;
    error_record_count     <= cnt;
  endtask : ctx

  task automatic acc(input logic [2:0] k, input logic el1, input logic trap, input logic [5:0] ec);
    @(posedge core_clk);
    acc_valid    <= 1'b1;
    acc_kind     <= k;
    acc_from_el1 <= el1;
    acc_from_el0 <= ~el1;
    @(posedge core_clk);
    acc_valid    <= 1'b0;
    @(negedge core_clk);
    chk("acc_done", acc_done, 1'b1);
    chk("acc_trap", acc_trap_el2, trap);
    chk("acc_ec", acc_ec, ec);
  endtask : acc

  task automatic xl(input logic [3:0] s2, input logic [7:0] s1);
    @(posedge core_clk);
    xl_valid <= 1'b1;
    s2_attr  <= s2;
    {s1_device, s1_dev_kind, s1_cacheable, s1_wb, s1_alloc, s1_tagged} <= s1;
    @(posedge core_clk);
    xl_valid <= 1'b0;
    @(negedge core_clk);
    chk("xl_done", xl_done, 1'b1);
  endtask : xl

  // ********
  // scenarios
  // ********
  task automatic t_regs;
    rd(8'h04, 32'h0, "cfg_reset");
    wr(8'h04, 32'h000FC000);
    rd(8'h04, 32'h000FC000, "cfg_hi");
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0, "cfg_lo");
    rd(8'h1C, 32'h0, "unmapped");
    ctx(1'b1, 1'b0, 16'h0);
    wr(8'h04, 32'h000FC000);
    rd(8'h04, 32'h000F4000, "fault_injection_access_enable_rsvd");
    ctx(1'b1, 1'b0, 16'h1);
  endtask : t_regs

  // monitor outputs are registered after the config, hence two falling edges more
  task automatic t_monitor;
    wr(8'h04, 32'h0);
    repeat (2) @(negedge core_clk);
    chk("virt_off", monitor_virt_on, 1'b0);
    chk("offset_off", monitor_offset_out, 64'h0);
    wr(8'h04, 32'h00080000);
    repeat (2) @(negedge core_clk);
    chk("virt_on", monitor_virt_on, 1'b1);
    chk("offset_on", monitor_offset_out, monitor_offset_in);
  endtask : t_monitor

  task automatic t_traps;
    wr(8'h04, 32'h00070000);
    acc(3'h0, 1'b1, 1'b1, 6'h18);
    acc(3'h1, 1'b1, 1'b0, 6'h0);
    acc(3'h2, 1'b1, 1'b1, 6'h18);
    acc(3'h3, 1'b1, 1'b1, 6'h18);
    acc(3'h4, 1'b1, 1'b1, 6'h18);
    acc(3'h5, 1'b0, 1'b1, 6'h0);
    acc(3'h6, 1'b1, 1'b0, 6'h0);
    ctx(1'b1, 1'b1, 16'h1);
    acc(3'h0, 1'b1, 1'b0, 6'h0);
    acc(3'h2, 1'b1, 1'b0, 6'h0);
    rd(8'h04, 32'h00070000, "direct_read");
    rd(8'h14, 32'h10, "live_host");
    ctx(1'b0, 1'b0, 16'h1);
    rd(8'h14, 32'h0E, "live_el2_off");
    acc(3'h4, 1'b1, 1'b0, 6'h0);
    acc(3'h0, 1'b1, 1'b0, 6'h0);
    ctx(1'b1, 1'b0, 16'h1);
    wr(8'h04, 32'h00008000);
    acc(3'h4, 1'b1, 1'b0, 6'h0);
    acc(3'h5, 1'b1, 1'b0, 6'h0);
  endtask : t_traps

  task automatic t_irq;
    wr(8'h0C, 32'hF);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h00040000);
    acc(3'h0, 1'b1, 1'b1, 6'h18);
    rd(8'h08, 32'h1, "status_masked");
    chk("irq_masked", irq, 1'b0);
    wr(8'h10, 32'h1);
    repeat (2) @(negedge core_clk);
    chk("irq_on", irq, 1'b1);
    wr(8'h0C, 32'h1);
    repeat (2) @(negedge core_clk);
    chk("irq_off", irq, 1'b0);
    rd(8'h0C, 32'h0, "clear_wo");
  endtask : t_irq

  // the stored control reaches translation only through an invalidate
  task automatic t_combine;
    wr(8'h04, 32'h00004000);
    xl(4'hB, 8'h1B);
    chk("baseline", {fin_device, fin_s2_bit5_ignored}, 2'h0);
    @(posedge core_clk);
    tlb_invalidate <= 1'b1;
    @(posedge core_clk);
    tlb_invalidate <= 1'b0;
    xl(4'hB, 8'h1B);
    chk("fwb_dev", {fin_all, fin_s2_bit5_ignored}, 9'h1C1);
    for (int i = 0; i < 8; i++)
    begin
      xl(S2T[i], S1T[i]);
      chk("fwb_table", fin_all, EXT[i]);
    end
  endtask : t_combine

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ********
  // clock, watchdog and main sequence
  // ********
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {nrst, reg_wr, reg_rd, acc_valid, xl_valid, tlb_invalidate, host_el2_mode} = '0;
    {general_exception_trap, acc_kind, acc_from_el1, acc_from_el0, s2_attr} = '0;
    {s1_device, s1_dev_kind, s1_cacheable, s1_wb, s1_alloc, s1_tagged, reg_addr} = '0;
    {el2_enabled, pou_before_icache, fi_model_owned} = 3'h7;
    reg_wdata          = 32'h0;
    error_record_count = 16'h1;
    monitor_offset_in  = 64'h0123456789ABCDEF;
    mismatches         = 0;
    checks_done        = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_monitor();
    t_traps();
    t_irq();
    t_combine();
    print_verdict();
  end
endmodule : hyp_trap_and_s2_attr_ctrl_tb_top

`default_nettype wire

// >>> tb/hyp_trap_checker.sv
// checker: concurrent assertions on the hypervisor trap block ports
`timescale 1ns/1ps
`default_nettype none

module hyp_trap_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        el2_enabled,
  input wire logic        host_el2_mode,
  input wire logic        general_exception_trap,
  input wire logic        acc_valid,
  input wire logic [2:0]  acc_kind,
  input wire logic        acc_done,
  input wire logic        acc_trap_el2,
  input wire logic [5:0]  acc_ec,
  input wire logic        monitor_virt_on,
  input wire logic [63:0] monitor_offset_out,
  input wire logic        tlb_invalidate,
  input wire logic        xl_valid,
  input wire logic [3:0]  s2_attr,
  input wire logic        s1_device,
  input wire logic        fin_device,
  input wire logic [1:0]  fin_dev_kind,
  input wire logic        fin_cacheable,
  input wire logic        fin_wb,
  input wire logic [1:0]  fin_alloc,
  input wire logic        fin_tagged,
  input wire logic        fin_s2_bit5_ignored
);
  // ********
  // assertions
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // stage 2 requests under the cached forced write-back copy; s2_attr[2] is bit 4
  sequence s_fwb_dev_req;
    xl_valid && fin_s2_bit5_ignored && !s2_attr[2] && !s1_device;
  endsequence
  sequence s_fwb_nc_req;
    xl_valid && fin_s2_bit5_ignored && s2_attr[2] && !s2_attr[1] && !s1_device;
  endsequence

  a_monitor_off_zero: assert property (
    !monitor_virt_on |-> monitor_offset_out == 64'h0)
    else $error("offset visible while virtualization off");
  a_sys_trap_class: assert property (
    acc_done && acc_trap_el2 && $past(acc_kind) != 3'h5 |-> acc_ec == 6'h18)
    else $error("system trap without class 0x18");
  a_el2_off_quiet: assert property (
    acc_valid && !el2_enabled && acc_kind != 3'h5 |=> !acc_trap_el2)
    else $error("trap while EL2 disabled");
  a_host_mode_mask: assert property (
    acc_valid && host_el2_mode && general_exception_trap && acc_kind < 3'h4
    |=> !acc_trap_el2)
    else $error("cache trap taken in host mode");
  a_fwb_dev_kind: assert property (
    s_fwb_dev_req |=> fin_device && fin_dev_kind == $past(s2_attr[1:0]))
    else $error("forced device kind wrong");
  a_fwb_noncache: assert property (
    s_fwb_nc_req |=> !fin_device && !fin_cacheable && fin_alloc == 2'h0)
    else $error("forced non-cacheable wrong");
  a_tagged_full_wb: assert property (
    fin_tagged |-> fin_cacheable && fin_wb && fin_alloc == 2'h3)
    else $error("tagged without full write-back");
  a_fwb_copy_hold: assert property (
    $changed(fin_s2_bit5_ignored) |-> $past(tlb_invalidate) || $past(tlb_invalidate, 2))
    else $error("cached copy moved without invalidate");
endmodule : hyp_trap_checker

bind hyp_trap_and_s2_attr_ctrl hyp_trap_checker i_hyp_trap_checker (
  .core_clk, .nrst, .el2_enabled, .host_el2_mode, .general_exception_trap, .acc_valid,
  .acc_kind, .acc_done, .acc_trap_el2, .acc_ec, .monitor_virt_on, .monitor_offset_out,
  .tlb_invalidate, .xl_valid, .s2_attr, .s1_device, .fin_device, .fin_dev_kind,
  .fin_cacheable, .fin_wb, .fin_alloc, .fin_tagged, .fin_s2_bit5_ignored
);

`default_nettype wire
